/* inc/ocd_pkg.sv */
// shared constants and types of the octal low-side driver control block
package ocd_pkg;

	// clock and protection timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int DIAG_FILTER_TIME_NS = 15000;
	localparam int SCB_DELAY_NS = 200;
	// least times: round up to whole cycles
	localparam int DIAG_FILTER_CYC = (DIAG_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCB_DELAY_CYC = (SCB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLT_W = 12;
	localparam int NCH = 8;
	localparam int NPAR = 2;
	localparam int WORD_W = 8;

	// apb register map (byte addresses)
	localparam logic [11:0] REG_CMD_OFS = 12'h000;
	localparam logic [11:0] REG_STAT_OFS = 12'h004;
	localparam logic [11:0] REG_CTRL_OFS = 12'h008;
	// status register fields
	localparam int STAT_DRV_LSB = 0;
	localparam int STAT_OVL_LSB = 8;
	localparam int STAT_REG_LSB = 16;
	// control register fields
	localparam int CTRL_LINK_EN_BIT = 0;

	// reset values
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic LINK_EN_RST = 1'b1;
	// sync order: clear_n, uv, select_low, sclk, sdi, direct_a, direct_b, sense
	localparam logic [24:0] SYNC_RST = 25'h14c_0000;

	// analog comparator results, one bit per channel; hot only for the regulated pair
	typedef struct packed {
		logic [7:0] above;
		logic [7:0] overcur;
		logic [1:0] hot;
	} ocd_sense_t;

	// pin inputs gathered for synchronisation
	typedef struct packed {
		logic clear_n;
		logic uv;
		logic sel_n;
		logic sclk;
		logic sdi;
		logic dir_a_n;
		logic dir_b_n;
		ocd_sense_t sense;
	} ocd_pins_t;

endpackage

/* hw/ocd_ctrl.sv */
// control, serial link and protection logic of the octal low-side driver
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ocd_ctrl
	import ocd_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic external_clear_low,
	input wire logic undervoltage,
	input wire logic select_low,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic direct_on_in_a,
	input wire logic direct_on_in_b,
	input wire ocd_sense_t sense,
	output logic sdo,
	output logic sdo_oe,
	output logic [NCH-1:0] ch_on,
	output logic [NPAR-1:0] cur_reg,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	////////////////////////////////////////////////////////////////////////////////
	// functions

	// filter length per channel: long diag filter for the regulated pair
	function automatic logic [FLT_W-1:0] flt_limit(input int ch);
		if (ch < NPAR) begin
			return FLT_W'(DIAG_FILTER_CYC);
		end
		return FLT_W'(SCB_DELAY_CYC);
	endfunction

	// register decode for the error path; read and write paths compare paddr themselves
	function automatic logic addr_hit(input logic [11:0] a);
		return (a == REG_CMD_OFS) || (a == REG_STAT_OFS) || (a == REG_CTRL_OFS);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	ocd_pins_t pins_in;
	ocd_pins_t sync1_ff;
	ocd_pins_t sync2_ff;
	ocd_pins_t sync3_ff;
	logic clr;
	logic link_en_ff;
	logic sel_fall;
	logic sel_rise;
	logic sclk_fall;
	logic sclk_rise;
	logic link_active;
	logic xfer;
	logic [WORD_W-1:0] shift_ff;
	logic [2:0] edge_cnt_ff;
	logic full_ff;
	logic [NCH-1:0] cmd_ff;
	logic [NCH-1:0] flt_lat_ff;
	logic [NCH-1:0] ovl_ff;
	logic [NCH-1:0] blk_ff;
	logic [FLT_W-1:0] flt_cnt_ff [NCH];
	logic [NCH-1:0] par_on;
	logic [NCH-1:0] par_mode;
	logic [NCH-1:0] req;
	logic [NCH-1:0] status_vec;
	logic [NCH-1:0] trip;
	logic [NCH-1:0] nxt_blk;
	logic [NCH-1:0] nxt_ovl;
	logic [NPAR-1:0] nxt_reg;
	logic [NCH-1:0] cond;
	logic acc;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	assign pins_in = '{clear_n: external_clear_low, uv: undervoltage, sel_n: select_low, sclk: sclk, sdi: sdi,
		dir_a_n: direct_on_in_a, dir_b_n: direct_on_in_b, sense: sense};

	// third stage only feeds edge detection; inactive levels keep channels off
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sync1_ff <= SYNC_RST;
			sync2_ff <= SYNC_RST;
			sync3_ff <= SYNC_RST;
		end else begin
			sync1_ff <= pins_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// synchronous clear from pin or undervoltage, delayed by the sync delay
	assign clr = !sync2_ff.clear_n || sync2_ff.uv;

	////////////////////////////////////////////////////////////////////////////////
	// serial link edge detection

	assign sel_fall = link_en_ff && sync3_ff.sel_n && !sync2_ff.sel_n;
	assign sel_rise = link_en_ff && !sync3_ff.sel_n && sync2_ff.sel_n;
	assign link_active = link_en_ff && !sync2_ff.sel_n && !sync3_ff.sel_n;
	// select moves only with clock low, so select and clock edges never coincide
	assign sclk_fall = link_active && sync3_ff.sclk && !sync2_ff.sclk;
	assign sclk_rise = link_active && !sync3_ff.sclk && sync2_ff.sclk;
	assign xfer = sel_rise && full_ff && (edge_cnt_ff == 3'd0);

	////////////////////////////////////////////////////////////////////////////////
	// channel request and status mapping

	always_comb begin
		par_on = '0;
		par_on[NPAR-1:0] = {!sync2_ff.dir_b_n, !sync2_ff.dir_a_n};
		req = cmd_ff | par_on;
		par_mode = par_on & ~cmd_ff;
		status_vec = flt_lat_ff;
		for (int n = 0; n < NPAR; n++) begin
			if (par_mode[n]) begin
				status_vec[n] = flt_lat_ff[n] ^ ch_on[n];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shift register, edge counter and command latch

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			shift_ff <= '0;
			edge_cnt_ff <= 3'd0;
			full_ff <= 1'b0;
			cmd_ff <= CMD_RST;
		end else if (clr) begin
			shift_ff <= '0;
			edge_cnt_ff <= 3'd0;
			full_ff <= 1'b0;
			cmd_ff <= CMD_RST;
		end else if (sel_fall) begin
			shift_ff <= status_vec;
			edge_cnt_ff <= 3'd0;
			full_ff <= 1'b0;
		end else if (xfer) begin
			cmd_ff <= shift_ff;
		end else if (sclk_fall) begin
			shift_ff <= {shift_ff[WORD_W-2:0], sync2_ff.sdi};
			edge_cnt_ff <= edge_cnt_ff + 3'd1;
			if (edge_cnt_ff == 3'd7) begin
				full_ff <= 1'b1;
			end
		end
	end

	// serial output: first bit at select fall, next bit on each rising clock
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
		end else if (clr || sel_rise || !link_en_ff) begin
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
		end else if (sel_fall) begin
			sdo <= status_vec[NCH-1];
			sdo_oe <= 1'b1;
		end else if (sclk_rise) begin
			sdo <= shift_ff[WORD_W-1];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault latches: cleared at select fall, capture resumes in the same cycle

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			flt_lat_ff <= '0;
		end else if (clr) begin
			flt_lat_ff <= '0;
		end else if (sel_fall) begin
			flt_lat_ff <= sync2_ff.sense.above;
		end else begin
			flt_lat_ff <= flt_lat_ff | sync2_ff.sense.above;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// protection filters and trip decisions

	always_comb begin
		for (int n = 0; n < NCH; n++) begin
			cond[n] = ch_on[n] && (sync2_ff.sense.overcur[n] || (sync2_ff.sense.above[n] && !par_mode[n]));
			trip[n] = cond[n] && (flt_cnt_ff[n] == flt_limit(n));
		end
		nxt_reg = '0;
		nxt_ovl = '0;
		// regulation holds while the overcurrent lasts; serial short to battery offs
		for (int n = 0; n < NPAR; n++) begin
			nxt_reg[n] = ch_on[n] && sync2_ff.sense.overcur[n] && (trip[n] || cur_reg[n]);
			nxt_ovl[n] = (trip[n] && sync2_ff.sense.above[n] && !par_mode[n])
				|| (ch_on[n] && sync2_ff.sense.hot[n]);
		end
		for (int n = NPAR; n < NCH; n++) begin
			nxt_ovl[n] = trip[n];
		end
		// a new trip wins over a clear in the same cycle
		nxt_blk = (xfer ? '0 : blk_ff) | nxt_ovl;
	end

	// saturating filter counters, restarted whenever the condition drops
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int n = 0; n < NCH; n++) begin
				flt_cnt_ff[n] <= '0;
			end
		end else begin
			for (int n = 0; n < NCH; n++) begin
				if (clr || !cond[n]) begin
					flt_cnt_ff[n] <= '0;
				end else if (flt_cnt_ff[n] != flt_limit(n)) begin
					flt_cnt_ff[n] <= flt_cnt_ff[n] + FLT_W'(1);
				end
			end
		end
	end

	// overload status and switch-off block
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ovl_ff <= '0;
			blk_ff <= '0;
		end else if (clr) begin
			ovl_ff <= '0;
			blk_ff <= '0;
		end else begin
			ovl_ff <= (sel_fall ? '0 : ovl_ff) | nxt_ovl;
			blk_ff <= nxt_blk;
		end
	end

	// channel drive; an overload cuts the drive in the cycle it is seen
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ch_on <= '0;
			cur_reg <= '0;
		end else if (clr) begin
			ch_on <= '0;
			cur_reg <= '0;
		end else begin
			ch_on <= req & ~nxt_blk;
			cur_reg <= nxt_reg & ~nxt_blk[NPAR-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb slave: no wait state, answer in the cycle after setup

	assign acc = psel && penable && pready;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (psel && !penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !addr_hit(paddr);
			prdata <= '0;
			if (!pwrite) begin
				case (paddr)
					REG_CMD_OFS: begin
						prdata <= {24'h00_0000, cmd_ff};
					end
					REG_STAT_OFS: begin
						prdata[STAT_DRV_LSB +: NCH] <= ch_on;
						prdata[STAT_OVL_LSB +: NCH] <= ovl_ff;
						prdata[STAT_REG_LSB +: NPAR] <= cur_reg;
					end
					REG_CTRL_OFS: begin
						prdata[CTRL_LINK_EN_BIT] <= link_en_ff;
					end
					default: begin
						prdata <= '0;
					end
				endcase
			end
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// control register; the link enable gates the whole serial path
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			link_en_ff <= LINK_EN_RST;
		end else if (clr) begin
			link_en_ff <= LINK_EN_RST;
		end else if (acc && pwrite && (paddr == REG_CTRL_OFS)) begin
			link_en_ff <= pwdata[CTRL_LINK_EN_BIT];
		end
	end

endmodule

/* dv/ocd_ctrl_sva.sv */
// concurrent checks on the driver control ports
`timescale 1ns/1ps
module ocd_ctrl_sva
	import ocd_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic external_clear_low,
	input wire logic undervoltage,
	input wire logic select_low,
	input wire logic direct_on_in_a,
	input wire ocd_sense_t sense,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic [NCH-1:0] ch_on,
	input wire logic [NPAR-1:0] cur_reg,
	input wire logic pslverr
);
	default clocking ck @(posedge mclk); endclocking
	default disable iff (!resetn);
////////////////////////////////////////
	// cycles channel 4 stays on into overcurrent; long, so counted not repeated
	logic [7:0] scb_cnt_ff;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			scb_cnt_ff <= 8'h00;
		end else begin
			scb_cnt_ff <= (ch_on[3] && sense.overcur[3]) ? scb_cnt_ff + 8'h01 : 8'h00;
		end
	end
	// cycles the channel 1 overcurrent has lasted, saturating
	logic [11:0] oc_cnt_ff;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			oc_cnt_ff <= 12'h000;
		end else if (!sense.overcur[0]) begin
			oc_cnt_ff <= 12'h000;
		end else if (oc_cnt_ff != 12'hfff) begin
			oc_cnt_ff <= oc_cnt_ff + 12'h001;
		end
	end
	chk_clear_off: assert property (!external_clear_low [*6] |-> ch_on == '0)
		else $error("channel on during clear");
	chk_uv_off: assert property (undervoltage [*6] |-> ch_on == '0 && cur_reg == '0)
		else $error("channel on during undervoltage");
	chk_oe_idle: assert property (select_low [*6] |-> !sdo_oe)
		else $error("serial output driven while deselected");
	chk_sdo_quiet: assert property (!sdo_oe |-> !sdo)
		else $error("serial data not parked");
	chk_par_on: assert property ((!direct_on_in_a && external_clear_low && !undervoltage
		&& sense == '0) [*8] |-> ch_on[0])
		else $error("direct input ignored");
	chk_hot_off: assert property (sense.hot[1] && ch_on[1] |-> ##[1:5] !ch_on[1])
		else $error("hot channel stays on");
	chk_scb_bound: assert property (scb_cnt_ff < SCB_DELAY_CYC + 8)
		else $error("overcurrent shutoff too late");
	chk_filter_min: assert property ($rose(cur_reg[0]) |-> oc_cnt_ff >= DIAG_FILTER_CYC)
		else $error("regulation before filter time");
	chk_oe_start: assert property ($fell(select_low) && external_clear_low && !undervoltage
		|-> ##[2:6] sdo_oe)
		else $error("serial output not driven after select");
	cover property ($rose(cur_reg[0]));
	cover property ($fell(ch_on[3]));
	cover property (pslverr);
endmodule
bind ocd_ctrl ocd_ctrl_sva i_ocd_ctrl_sva (.*);

/* dv/ocd_host_model.sv */
// serial host: makes the link clock, select and data
`timescale 1ns/1ps
module ocd_host_model (
	output logic select_low,
	output logic sclk,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		select_low = 1'b1;
		sclk = 1'b0;
		sdi = 1'b1;
	end
////////////////////////////////////////
	// one frame, msb first; clock stands low outside frames
	task automatic xfer(input logic [15:0] w, input int n, input int hp, output logic [7:0] st);
		st = 8'h00;
		#1; // keeps pin changes off the system clock edge
		select_low = 1'b0;
		#100;
		// data moves with the rising clock; both ends sample on the falling one
		for (int i = n - 1; i >= 0; i--) begin
			#hp sclk = 1'b1;
			sdi = w[i];
			#hp st = {st[6:0], sdo};
			sclk = 1'b0;
		end
		#100 select_low = 1'b1;
		sdi = ~sdi; // released line must not look stable
		#200;
	endtask
endmodule

/* dv/ocd_ctrl_bench.sv */
// self-checking bench of the driver control block
`timescale 1ns/1ps
module ocd_ctrl_bench;
	import ocd_pkg::*;
	typedef struct {logic [15:0] w; int n; logic [7:0] ab; logic [7:0] exp;} ocd_row_t;
	logic mclk, resetn, external_clear_low, undervoltage, direct_on_in_a, direct_on_in_b;
	logic select_low, sclk, sdi, sdo, sdo_oe, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [NCH-1:0] ch_on;
	logic [NPAR-1:0] cur_reg;
	logic [7:0] st;
	ocd_sense_t sense;
	int n_fail = 0;
	int check_count = 0;
	// frame word, clock count, above pattern, command expected after
	ocd_row_t rows[6] = '{'{16'h00a5, 8, 8'h42, 8'ha5}, '{16'h003c, 7, 8'h18, 8'ha5},
		'{16'h5a81, 16, 8'h02, 8'h81}, '{16'h00ff, 0, 8'h00, 8'h81},
		'{16'h0000, 8, 8'h7e, 8'h00}, '{16'h01ff, 9, 8'h00, 8'h00}};
	ocd_ctrl i_ocd_ctrl (.*);
	ocd_host_model i_ocd_host_model (.*);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// one transfer; no fixed latency assumed, waits for pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic complete_run();
		if (n_fail == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// hang guard, well beyond the longest filter wait
	initial begin
		#100000;
		n_fail++;
		complete_run();
	end
	initial begin
		{resetn, external_clear_low, undervoltage, direct_on_in_a, direct_on_in_b} = 5'b01011;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		sense = '0;
		cyc(2);
		resetn <= 1'b1;
		cyc(4);
		chk("ch_on", ch_on, 0);
		apb(0, REG_CTRL_OFS, 0);
		chk("ctrl", rd, 1);
		// table: link clock of 64 ns period
		for (int i = 0; i < 6; i++) begin
			sense.above <= rows[i].ab;
			cyc(20);
			i_ocd_host_model.xfer(rows[i].w, rows[i].n, 32, st);
			if (rows[i].n == 8) chk("status", st, rows[i].ab);
			chk("ch_on", ch_on, rows[i].exp);
			apb(0, REG_CMD_OFS, 0);
			chk("cmd", rd, rows[i].exp);
		end
		apb(0, 12'h00c, 0);
		chk("err", err, 1);
		chk("rdata", rd, 0);
		apb(1, REG_CMD_OFS, 32'h0000_00ff);
		apb(0, REG_CMD_OFS, 0);
		chk("cmd_ro", rd, 0);
		apb(1, REG_CTRL_OFS, 0);
		apb(0, REG_CTRL_OFS, 0);
		chk("ctrl", rd, 0);
		apb(1, REG_CTRL_OFS, 1);
		direct_on_in_a <= 1'b0;
		cyc(12);
		chk("dir_on", ch_on[1:0], 2'b01);
		i_ocd_host_model.xfer(16'h0000, 8, 32, st);
		chk("dir_stat", st, 8'h01);
		cyc(1);
		sense.overcur[0] <= 1'b1;
		cyc(3700);
		chk("reg_early", cur_reg[0], 0);
		cyc(100);
		chk("reg_on", {ch_on[0], cur_reg[0]}, 2'b11);
		sense.overcur[0] <= 1'b0;
		direct_on_in_b <= 1'b0;
		cyc(12);
		sense.hot[1] <= 1'b1;
		cyc(8);
		chk("hot_off", ch_on[1], 0);
		sense.hot[1] <= 1'b0;
		cyc(8);
		apb(0, REG_STAT_OFS, 0);
		chk("hot_ovl", rd[9], 1);
		chk("hot_stay", ch_on[1], 0);
		{direct_on_in_a, direct_on_in_b} <= 2'b11;
		i_ocd_host_model.xfer(16'h0018, 8, 32, st);
		cyc(1);
		chk("ser_on", ch_on, 8'h18);
		sense.overcur[3] <= 1'b1;
		sense.above[4] <= 1'b1;
		cyc(70);
		chk("scb_off", ch_on, 0);
		apb(0, REG_STAT_OFS, 0);
		chk("scb_ovl", rd[15:8], 8'h18);
		sense <= '0;
		cyc(8);
		chk("scb_stay", ch_on, 0);
		// clear pin first, then undervoltage
		for (int k = 0; k < 2; k++) begin
			i_ocd_host_model.xfer(16'h0018, 8, 32, st);
			chk("scb_new", ch_on, 8'h18);
			cyc(1);
			{external_clear_low, undervoltage} <= {k[0], k[0]};
			cyc(8);
			chk("clr_off", ch_on, 0);
			apb(0, REG_CMD_OFS, 0);
			chk("clr_cmd", rd, 0);
			{external_clear_low, undervoltage} <= 2'b10;
			cyc(4);
		end
		// sticky latch: first read after a fault goes away is stale, the second is valid
		sense.above <= 8'h20;
		cyc(8);
		i_ocd_host_model.xfer(16'h0000, 8, 32, st);
		chk("stat_off_hi", st, 8'h20);
		cyc(1);
		sense.above <= 8'h00;
		cyc(8);
		i_ocd_host_model.xfer(16'h0000, 8, 32, st);
		chk("stat_stale", st, 8'h20);
		i_ocd_host_model.xfer(16'h0000, 8, 32, st);
		chk("stat_second", st, 8'h00);
		complete_run();
	end
endmodule
